// ==== sleep_ctl_pkg.sv ====
// Shared constants and types for the sleep and wake controller.
// Assumes an 8-bit special-function register port inside the chip.
package sleep_ctl_pkg;

  // Register addresses on the special-function register port
  localparam logic [7:0] ADDR_CLOCK_CTL = 8'h80;
  localparam logic [7:0] ADDR_STATE = 8'ha1;
  localparam logic [7:0] ADDR_WAKE_DET = 8'haf;
  localparam logic [7:0] ADDR_WAKE_CFG = 8'hc9;

  // clock_switch_control fields
  localparam int BIT_MAIN_SEL = 0;
  localparam int BIT_SLEEP_LO = 1;
  localparam int BIT_SLEEP_HI = 2;
  localparam int BIT_DISPLAY_STOP = 3;
  localparam int BIT_METER_STOP = 4;
  localparam int BIT_QUICK_SLEEP = 5;
  localparam int BIT_QUICK_WAKE = 6;
  localparam int BIT_METER_SEL = 7;
  localparam logic [7:0] CLOCK_CTL_RESET = 8'h00;
  // Bits that a wake without reset clears: quick clocks and sleep level
  localparam logic [7:0] WAKE_CLEAR_MASK = 8'h66;

  // Sleep level codes in bits 2:1
  localparam logic [1:0] SLEEP_NONE = 2'b00;
  localparam logic [1:0] SLEEP_LIGHT_A = 2'b01;
  localparam logic [1:0] SLEEP_LIGHT_B = 2'b11;
  localparam logic [1:0] SLEEP_DEEP = 2'b10;

  // State register fields
  localparam int BIT_SUPPLY_GOOD = 0;
  localparam int BIT_RTC_FLAG = 2;
  localparam int BIT_IO_FLAG = 3;

  // wake_config_register fields
  localparam int BIT_NO_RESET = 0;
  localparam int BIT_PORT_ZERO_EN = 1;
  localparam logic [1:0] WAKE_CFG_RESET = 2'b00;

  // wake_detect_register fields
  localparam int BIT_PIN_WAKE = 0;
  localparam int BIT_P02_WAKE = 1;
  localparam int BIT_P03_WAKE = 2;
  localparam int BIT_PULSE_WAKE = 3;

  // Wake pins: four dedicated pins plus two port-zero pins
  localparam int NUM_DEDICATED_PINS = 4;
  localparam int NUM_WAKE_PINS = 6;
  localparam int PIN_P02 = 4;
  localparam int PIN_P03 = 5;

  // A level must last more than this many crystal cycles
  localparam int OSC_MIN_CYCLES = 4;

  typedef enum logic [1:0] {st_crystal, st_working, st_light_sleep, st_deep_sleep} sys_state_e;

  typedef struct packed {
    logic main_regulator;
    logic digital_supply;
    logic osc_on;
    logic low_power_reference;
    logic rtc_run;
    logic cpu_run;
    logic mem_periph_run;
    logic main_clock_en;
    logic main_clock_pll;
    logic aux_clock_en;
    logic pll_en;
    logic metering_clock_en;
    logic metering_clock_pll;
    logic display_clock_en;
  } power_ctl_s;

endpackage

// ==== wake_pin_filter.sv ====
// Qualifies one wake pin: synchroniser, then a stable-level counter.
// Assumes i_tick pulses once per crystal clock period.
`timescale 1ns/1ps
module wake_pin_filter #(
  parameter int MIN_CYCLES = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_pin,
  output logic o_edge
);
  localparam int CW = $clog2(MIN_CYCLES + 2);
  localparam logic [CW-1:0] LIMIT = CW'(MIN_CYCLES + 1);

  logic sync_a, sync_b;
  logic level, next_level;
  logic [CW-1:0] count, next_count;
  logic next_edge;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= i_pin;
      sync_b <= sync_a;
    end
  end

  // A new level is accepted only after it outlasts the minimum; glitches restart the count
  always_comb begin
    next_level = level;
    next_count = count;
    next_edge = 1'b0;
    if (sync_b == level) begin
      next_count = '0;
    end else if (i_tick) begin
      if (count == LIMIT - CW'(1)) begin
        next_level = sync_b;
        next_count = '0;
        next_edge = 1'b1;
      end else begin
        next_count = count + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level <= 1'b0;
      count <= '0;
      o_edge <= 1'b0;
    end else begin
      level <= next_level;
      count <= next_count;
      o_edge <= next_edge;
    end
  end
endmodule

// ==== sleep_wake_ctrl.sv ====
// System state, sleep entry and wake control with its registers.
// Assumes a synchronous register port and wake inputs on i_clk.
// How it works
// - Upper reset levels return to crystal state
// - Crystal state: supplies always on, processor runs
// - PLL enabled and selected gives working state
// - Supply bit low, crystal, gating enters sleep
// - Sleep keeps RTC; display, metering unless stopped
// - Light sleep wakes on IO/RTC/pulse/supply, resets
// - Deep sleep wakes only on IO or supply
// - No-reset wake resumes, clears bits 6:5, 2:1
// - Enabled wake pin: either edge, levels over four
// - Port-zero pins wake only when enabled together
// - IO flag set: detect bits name source
// - RTC with pulse flag means pulse wake
// - Processor may sleep while metering keeps PLL
// - Quick sleep: light sleep only, PLL off
// - Bit7 selects metering clock, reads source used
// - Codes 01/11 light sleep, 10 deep sleep
// - Bit0 selects main clock, reads source used
`timescale 1ns/1ps
module sleep_wake_ctrl #(
  parameter int OSC_DIV = 6104
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_level_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_supply_good_status,
  input wire logic i_pll_enable,
  input wire logic i_rtc_wake,
  input wire logic i_pulse_out,
  input wire logic i_supply_restore,
  input wire logic [sleep_ctl_pkg::NUM_DEDICATED_PINS-1:0] i_pin_input_en,
  input wire logic [sleep_ctl_pkg::NUM_WAKE_PINS-1:0] i_wake_pin,
  output sleep_ctl_pkg::power_ctl_s o_power,
  output logic o_wake_reset
);
  import sleep_ctl_pkg::*;

  localparam int DW = $clog2(OSC_DIV + 1);

  sys_state_e state, next_state;
  logic [7:0] clock_ctl, next_clock_ctl;
  logic [1:0] wake_cfg, next_wake_cfg;
  logic io_flag, next_io_flag, rtc_flag, next_rtc_flag;
  logic [3:0] wake_det, next_wake_det;
  logic quick_pll, next_quick_pll, pll_block, next_pll_block;
  logic [NUM_DEDICATED_PINS-1:0] pin_armed, next_pin_armed;
  logic [DW-1:0] div_count;
  logic osc_tick;
  logic [NUM_WAKE_PINS-1:0] pin_edge;
  logic next_wake_reset;
  logic [7:0] next_rdata;
  power_ctl_s next_power;
  logic sleeping, wr_ctl, pin_wake, p02_wake, p03_wake, io_wake, pulse_wake, rtc_wake, wake;
  logic next_pll_on, next_sleeping;

  // Crystal clock modelled as an enable pulse divided from the system clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_count <= '0;
    end else if (div_count == DW'(OSC_DIV - 1)) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + DW'(1);
    end
  end
  assign osc_tick = (div_count == DW'(OSC_DIV - 1));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WAKE_PINS; gi++) begin : g_pin
      wake_pin_filter #(
        .MIN_CYCLES(OSC_MIN_CYCLES)
      ) u_filter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_tick(osc_tick),
        .i_pin(i_wake_pin[gi]),
        .o_edge(pin_edge[gi])
      );
    end
  endgenerate

  assign sleeping = (state == st_light_sleep) || (state == st_deep_sleep);
  assign wr_ctl = i_sfr_wr && (i_sfr_addr == ADDR_CLOCK_CTL);
  assign pin_wake = |(pin_edge[NUM_DEDICATED_PINS-1:0] & pin_armed);
  assign p02_wake = pin_edge[PIN_P02] && wake_cfg[BIT_PORT_ZERO_EN];
  assign p03_wake = pin_edge[PIN_P03] && wake_cfg[BIT_PORT_ZERO_EN];
  assign io_wake = pin_wake || p02_wake || p03_wake;
  assign pulse_wake = (state == st_light_sleep) && i_pulse_out;
  assign rtc_wake = (state == st_light_sleep) && i_rtc_wake;
  assign wake = sleeping && (io_wake || pulse_wake || rtc_wake || i_supply_restore);

  always_comb begin
    next_state = state;
    next_clock_ctl = clock_ctl;
    next_wake_cfg = wake_cfg;
    next_io_flag = io_flag;
    next_rtc_flag = rtc_flag;
    next_wake_det = wake_det;
    next_quick_pll = quick_pll;
    next_pll_block = pll_block;
    next_pin_armed = pin_armed;
    next_wake_reset = 1'b0;
    if (i_level_reset) begin
      next_state = st_crystal;
      next_clock_ctl = CLOCK_CTL_RESET;
      next_wake_cfg = WAKE_CFG_RESET;
      next_quick_pll = 1'b0;
      next_pll_block = 1'b0;
    end else if (sleeping) begin
      if (wake) begin
        next_io_flag = io_flag || io_wake;
        next_rtc_flag = rtc_flag || rtc_wake || pulse_wake;
        next_wake_det[BIT_PIN_WAKE] = wake_det[BIT_PIN_WAKE] || pin_wake;
        next_wake_det[BIT_P02_WAKE] = wake_det[BIT_P02_WAKE] || p02_wake;
        next_wake_det[BIT_P03_WAKE] = wake_det[BIT_P03_WAKE] || p03_wake;
        next_wake_det[BIT_PULSE_WAKE] = wake_det[BIT_PULSE_WAKE] || pulse_wake;
        next_state = st_crystal;
        next_pll_block = 1'b0;
        next_quick_pll = 1'b0;
        if (wake_cfg[BIT_NO_RESET]) begin
          next_clock_ctl = clock_ctl & ~WAKE_CLEAR_MASK;
        end else begin
          next_clock_ctl = CLOCK_CTL_RESET;
          next_wake_reset = 1'b1;
        end
      end
    end else begin
      if (i_sfr_wr && (i_sfr_addr == ADDR_WAKE_CFG)) begin
        next_wake_cfg = i_sfr_wdata[1:0];
      end
      if (wr_ctl) begin
        next_clock_ctl = i_sfr_wdata;
        if (i_sfr_wdata[BIT_QUICK_SLEEP]) begin
          next_clock_ctl[BIT_MAIN_SEL] = 1'b0;
          next_quick_pll = 1'b0;
          next_pll_block = 1'b1;
        end else if (i_sfr_wdata[BIT_QUICK_WAKE]) begin
          next_clock_ctl[BIT_MAIN_SEL] = 1'b1;
          next_quick_pll = 1'b1;
          next_pll_block = 1'b0;
        end
      end else if (!i_supply_good_status && !clock_ctl[BIT_MAIN_SEL]) begin
        // Sleep is decided on the stored register, one cycle after the write
        if (clock_ctl[BIT_QUICK_SLEEP]) begin
          next_state = st_light_sleep;
        end else begin
          case (clock_ctl[BIT_SLEEP_HI:BIT_SLEEP_LO])
            SLEEP_LIGHT_A, SLEEP_LIGHT_B: next_state = st_light_sleep;
            SLEEP_DEEP: next_state = st_deep_sleep;
            default: next_state = state;
          endcase
        end
        if (next_state != state) begin
          next_pin_armed = i_pin_input_en;
          next_io_flag = 1'b0;
          next_rtc_flag = 1'b0;
          next_wake_det = '0;
        end
      end
      if (next_state == state) begin
        if (quick_pll || (i_pll_enable && !pll_block)) begin
          next_state = clock_ctl[BIT_MAIN_SEL] ? st_working : st_crystal;
        end else begin
          next_state = st_crystal;
        end
      end
    end
  end

  // Power and clock outputs follow the next state so they come from flops
  always_comb begin
    next_sleeping = (next_state == st_light_sleep) || (next_state == st_deep_sleep);
    next_pll_on = next_quick_pll || (i_pll_enable && !next_pll_block);
    next_power.main_regulator = 1'b1;
    next_power.digital_supply = 1'b1;
    next_power.osc_on = 1'b1;
    next_power.low_power_reference = 1'b1;
    next_power.rtc_run = 1'b1;
    next_power.cpu_run = !next_sleeping;
    next_power.mem_periph_run = !next_sleeping;
    next_power.main_clock_en = !next_sleeping;
    next_power.aux_clock_en = !next_sleeping;
    next_power.main_clock_pll = next_clock_ctl[BIT_MAIN_SEL] && next_pll_on;
    next_power.pll_en = next_pll_on;
    next_power.metering_clock_en = !next_clock_ctl[BIT_METER_STOP];
    next_power.metering_clock_pll = next_clock_ctl[BIT_METER_SEL] && next_pll_on;
    next_power.display_clock_en = !next_clock_ctl[BIT_DISPLAY_STOP];
  end

  // Select bits read back the source actually in use, not just the stored bit
  always_comb begin
    case (i_sfr_addr)
      ADDR_CLOCK_CTL: next_rdata = {o_power.metering_clock_pll, clock_ctl[BIT_QUICK_WAKE:BIT_SLEEP_LO],
                                    o_power.main_clock_pll};
      ADDR_STATE: next_rdata = {4'h0, io_flag, rtc_flag, 1'b0, i_supply_good_status};
      ADDR_WAKE_DET: next_rdata = {4'h0, wake_det};
      ADDR_WAKE_CFG: next_rdata = {6'h00, wake_cfg};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= st_crystal;
      clock_ctl <= CLOCK_CTL_RESET;
      wake_cfg <= WAKE_CFG_RESET;
      io_flag <= 1'b0;
      rtc_flag <= 1'b0;
      wake_det <= '0;
      quick_pll <= 1'b0;
      pll_block <= 1'b0;
      pin_armed <= '0;
      o_wake_reset <= 1'b0;
      o_sfr_rdata <= 8'h00;
      o_power <= '{main_regulator: 1'b1, digital_supply: 1'b1, osc_on: 1'b1, low_power_reference: 1'b1,
                   rtc_run: 1'b1, cpu_run: 1'b1, mem_periph_run: 1'b1, main_clock_en: 1'b1,
                   aux_clock_en: 1'b1, metering_clock_en: 1'b1, display_clock_en: 1'b1, default: 1'b0};
    end else begin
      state <= next_state;
      clock_ctl <= next_clock_ctl;
      wake_cfg <= next_wake_cfg;
      io_flag <= next_io_flag;
      rtc_flag <= next_rtc_flag;
      wake_det <= next_wake_det;
      quick_pll <= next_quick_pll;
      pll_block <= next_pll_block;
      pin_armed <= next_pin_armed;
      o_wake_reset <= next_wake_reset;
      o_sfr_rdata <= next_rdata;
      o_power <= next_power;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence quick_sleep_write;
    wr_ctl && i_sfr_wdata[BIT_QUICK_SLEEP] && !sleeping && !i_level_reset && !i_supply_good_status;
  endsequence
  sequence settle_quiet;
    !i_level_reset && !i_sfr_wr && !i_supply_good_status && !wake;
  endsequence

  chk_level_reset_crystal: assert property (i_level_reset |=> state == st_crystal && o_power.cpu_run)
    else $error("level reset did not return to crystal state");
  chk_supplies_always_on: assert property (state == st_crystal |-> o_power.main_regulator && o_power.osc_on
      && o_power.low_power_reference && o_power.rtc_run && o_power.cpu_run)
    else $error("crystal state supplies not all on");
  chk_working_entry: assert property (!sleeping && !i_level_reset && !i_sfr_wr
      && (quick_pll || (i_pll_enable && !pll_block)) && clock_ctl[BIT_MAIN_SEL]
      && (i_supply_good_status || clock_ctl[BIT_SLEEP_HI:BIT_SLEEP_LO] == SLEEP_NONE)
      |=> state == st_working && o_power.main_clock_pll)
    else $error("working state not entered");
  chk_deep_entry: assert property (!sleeping && !i_level_reset && !i_sfr_wr && !i_supply_good_status
      && !clock_ctl[BIT_MAIN_SEL] && !clock_ctl[BIT_QUICK_SLEEP] && clock_ctl[BIT_SLEEP_HI:BIT_SLEEP_LO] == SLEEP_DEEP
      |=> state == st_deep_sleep && !o_power.main_clock_en && !o_power.aux_clock_en)
    else $error("deep sleep not entered");
  chk_deep_ignores_rtc: assert property (state == st_deep_sleep && !io_wake && !i_supply_restore
      && !i_level_reset |=> state == st_deep_sleep)
    else $error("deep sleep left without io or supply wake");
  chk_wake_no_reset: assert property (wake && wake_cfg[BIT_NO_RESET] && !i_level_reset
      |=> (clock_ctl & WAKE_CLEAR_MASK) == 8'h00 && !o_wake_reset && o_power.cpu_run)
    else $error("wake without reset misbehaved");
  chk_wake_with_reset: assert property (wake && !wake_cfg[BIT_NO_RESET] && !i_level_reset
      |=> o_wake_reset && state == st_crystal ##1 !o_wake_reset)
    else $error("wake with reset pulse wrong");
  chk_quick_sleep_light: assert property (quick_sleep_write ##1 settle_quiet
      |=> state == st_light_sleep && !o_power.pll_en)
    else $error("quick sleep did not reach light sleep with pll off");
  chk_pulse_flags: assert property (pulse_wake && !i_level_reset
      |=> rtc_flag && wake_det[BIT_PULSE_WAKE])
    else $error("pulse wake flags not set");
endmodule

// ==== sleep_wake_partner.sv ====
// Far-side model: wake event sources and the raw wake pins.
// Assumes calls start just after a rising edge of i_clk.
`timescale 1ns/1ps
module sleep_wake_partner #(
  parameter int OSC_DIV = 4
) (
  input wire logic i_clk,
  output logic o_rtc_wake,
  output logic o_pulse_out,
  output logic o_supply_restore,
  output logic [sleep_ctl_pkg::NUM_WAKE_PINS-1:0] o_wake_pin
);
  import sleep_ctl_pkg::*;

  initial begin
    o_rtc_wake = 1'b0;
    o_pulse_out = 1'b0;
    o_supply_restore = 1'b0;
    o_wake_pin = '0;
  end

  // One-cycle event: 0 rtc, 1 metering pulse, 2 supply restoration
  task automatic fire(input int kind);
    o_rtc_wake = (kind == 0);
    o_pulse_out = (kind == 1);
    o_supply_restore = (kind == 2);
    @(posedge i_clk);
    #1;
    o_rtc_wake = 1'b0;
    o_pulse_out = 1'b0;
    o_supply_restore = 1'b0;
  endtask

  // Flip a pin and hold the new level; short holds model a glitch
  task automatic flip(input int pin, input int ticks);
    o_wake_pin[pin] = ~o_wake_pin[pin];
    repeat (ticks * OSC_DIV) @(posedge i_clk);
    #1;
  endtask
endmodule

// ==== sleep_wake_ctrl_bench.sv ====
// Self-checking bench for the sleep and wake controller.
// Assumes the firmware role is played here through register tasks.
`timescale 1ns/1ps
module sleep_wake_ctrl_bench;
  import sleep_ctl_pkg::*;
  localparam int OSCD = 4;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_level_reset;
  logic [7:0] i_sfr_addr;
  logic i_sfr_wr;
  logic [7:0] i_sfr_wdata;
  logic [7:0] o_sfr_rdata;
  logic i_supply_good_status;
  logic i_pll_enable;
  logic [NUM_DEDICATED_PINS-1:0] i_pin_input_en;
  logic rtc_w, pulse_w, restore_w;
  logic [NUM_WAKE_PINS-1:0] pins;
  power_ctl_s o_power;
  logic o_wake_reset;
  int err_count = 0;
  int checks_done = 0;
  int wake_resets = 0;
  int base;

  always #2.5 i_clk = ~i_clk;

  sleep_wake_ctrl #(.OSC_DIV(OSCD)) sleep_wake_ctrl_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_level_reset(i_level_reset), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .i_supply_good_status(i_supply_good_status), .i_pll_enable(i_pll_enable), .i_rtc_wake(rtc_w),
    .i_pulse_out(pulse_w), .i_supply_restore(restore_w), .i_pin_input_en(i_pin_input_en),
    .i_wake_pin(pins), .o_power(o_power), .o_wake_reset(o_wake_reset));

  sleep_wake_partner #(.OSC_DIV(OSCD)) sleep_wake_partner_inst (
    .i_clk(i_clk), .o_rtc_wake(rtc_w), .o_pulse_out(pulse_w), .o_supply_restore(restore_w),
    .o_wake_pin(pins));

  always @(posedge i_clk) begin
    if (o_wake_reset === 1'b1) begin
      wake_resets <= wake_resets + 1;
    end
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    cyc(1);
    i_sfr_wr = 1'b0;
  endtask

  // Read data is registered: it shows one edge after the address
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    i_sfr_addr = a;
    cyc(1);
    check(o_sfr_rdata, exp);
  endtask

  function automatic logic [7:0] pw();
    return {o_power.main_regulator, o_power.low_power_reference, o_power.rtc_run, o_power.cpu_run,
            o_power.main_clock_en, o_power.aux_clock_en, o_power.pll_en, o_power.main_clock_pll};
  endfunction

  // Remaining power fields that pw leaves out
  function automatic logic [7:0] px();
    return {2'b00, o_power.digital_supply, o_power.osc_on, o_power.mem_periph_run, o_power.metering_clock_en,
            o_power.metering_clock_pll, o_power.display_clock_en};
  endfunction

  // Entry lands one edge after the write; checked one edge later
  task automatic sleep_on(input logic [7:0] code);
    wr(ADDR_CLOCK_CTL, code);
    cyc(2);
    check(pw(), 8'he0);
    check(px(), {5'b00110, !code[BIT_METER_STOP], 1'b0, !code[BIT_DISPLAY_STOP]});
  endtask

  task automatic wake_wait;
    int n;
    n = 0;
    while (o_power.cpu_run !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    check({7'h0, o_power.cpu_run}, 8'h01);
  endtask

  initial begin
    #40000;
    err_count++;
    report_and_stop();
  end

  initial begin
    i_level_reset = 1'b0;
    i_sfr_addr = 8'h00;
    i_sfr_wr = 1'b0;
    i_sfr_wdata = 8'h00;
    i_supply_good_status = 1'b1;
    i_pll_enable = 1'b0;
    i_pin_input_en = '0;
    repeat (3) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    cyc(1);
    check(pw(), 8'hfc);
    check(px(), 8'h3d);
    rc(ADDR_CLOCK_CTL, 8'h00);
    rc(ADDR_WAKE_CFG, 8'h00);
    rc(8'h55, 8'h00);
    wr(ADDR_CLOCK_CTL, 8'h81);
    rc(ADDR_CLOCK_CTL, 8'h00);
    i_pll_enable = 1'b1;
    cyc(1);
    rc(ADDR_CLOCK_CTL, 8'h81);
    check(pw(), 8'hff);
    check(px(), 8'h3f);
    // Supply good blocks the sleep code
    wr(ADDR_CLOCK_CTL, 8'h04);
    cyc(3);
    check(pw(), 8'hfe);
    wr(ADDR_CLOCK_CTL, 8'h00);
    i_pll_enable = 1'b0;
    i_supply_good_status = 1'b0;
    cyc(2);
    // Light sleep by code 01, RTC wake with reset
    base = wake_resets;
    sleep_on(8'h02);
    sleep_wake_partner_inst.fire(0);
    wake_wait();
    rc(ADDR_STATE, 8'h04);
    rc(ADDR_WAKE_DET, 8'h00);
    rc(ADDR_CLOCK_CTL, 8'h00);
    check(8'(wake_resets - base), 8'h01);
    // Light sleep by code 11, pulse wake
    sleep_on(8'h06);
    sleep_wake_partner_inst.fire(1);
    wake_wait();
    rc(ADDR_STATE, 8'h04);
    rc(ADDR_WAKE_DET, 8'h08);
    // Deep sleep ignores RTC, pulse, glitches, disabled pins
    i_pin_input_en = 4'b0001;
    sleep_on(8'h04);
    sleep_wake_partner_inst.fire(0);
    cyc(1);
    sleep_wake_partner_inst.fire(1);
    sleep_wake_partner_inst.flip(0, 3);
    sleep_wake_partner_inst.flip(0, 3);
    sleep_wake_partner_inst.flip(1, 6);
    sleep_wake_partner_inst.flip(PIN_P02, 6);
    cyc(40);
    check({7'h0, o_power.cpu_run}, 8'h00);
    sleep_wake_partner_inst.flip(0, 6);
    wake_wait();
    rc(ADDR_STATE, 8'h08);
    rc(ADDR_WAKE_DET, 8'h01);
    // Port-zero pins enabled together
    wr(ADDR_WAKE_CFG, 8'h02);
    rc(ADDR_WAKE_CFG, 8'h02);
    sleep_on(8'h04);
    sleep_wake_partner_inst.flip(PIN_P03, 6);
    wake_wait();
    rc(ADDR_WAKE_DET, 8'h04);
    // Wake without reset keeps the clock stop bits
    wr(ADDR_WAKE_CFG, 8'h03);
    base = wake_resets;
    cyc(1);
    sleep_on(8'h1a);
    sleep_wake_partner_inst.fire(2);
    wake_wait();
    rc(ADDR_CLOCK_CTL, 8'h18);
    check(8'(wake_resets - base), 8'h00);
    // Quick sleep with a deep code still gives light sleep, PLL off
    wr(ADDR_WAKE_CFG, 8'h00);
    i_pll_enable = 1'b1;
    cyc(1);
    wr(ADDR_CLOCK_CTL, 8'h81);
    cyc(1);
    sleep_on(8'h24);
    sleep_wake_partner_inst.fire(0);
    wake_wait();
    // Firmware brings the PLL back after a reset wake, then a level reset clears both registers
    wr(ADDR_CLOCK_CTL, 8'h81);
    rc(ADDR_CLOCK_CTL, 8'h81);
    wr(ADDR_WAKE_CFG, 8'h03);
    i_level_reset = 1'b1;
    cyc(1);
    i_level_reset = 1'b0;
    rc(ADDR_CLOCK_CTL, 8'h00);
    rc(ADDR_WAKE_CFG, 8'h00);
    check(pw(), 8'hfe);
    // Quick wake starts the PLL on its own and selects it
    i_pll_enable = 1'b0;
    wr(ADDR_CLOCK_CTL, 8'h40);
    check(pw(), 8'hff);
    rc(ADDR_CLOCK_CTL, 8'h41);
    report_and_stop();
  end
endmodule
